// ---- npulse_pkg.sv ----
// package: register map, field layout and reset values of the n-pulse burst generator
package npulse_pkg;
  localparam logic [11:0] CTRL_OFFSET     = 12'h000;
  localparam logic [11:0] M_PSC_OFFSET    = 12'h004;
  localparam logic [11:0] M_ARR_OFFSET    = 12'h008;
  localparam logic [11:0] S_PSC_OFFSET    = 12'h00C;
  localparam logic [11:0] S_ARR_OFFSET    = 12'h010;
  localparam logic [11:0] S_CCR_OFFSET    = 12'h014;
  localparam logic [11:0] S_RCR_OFFSET    = 12'h018;
  localparam logic [11:0] UG_OFFSET       = 12'h01C;
  localparam logic [11:0] STATUS_OFFSET   = 12'h020;
  localparam logic [11:0] INT_EN_OFFSET   = 12'h024;
  localparam logic [11:0] INT_CLR_OFFSET  = 12'h028;
  localparam logic [11:0] M_CNT_OFFSET    = 12'h02C;
  localparam logic [11:0] S_CNT_OFFSET    = 12'h030;
  // control register fields
  localparam int MASTER_EN_BIT  = 0;
  localparam int SLAVE_EN_BIT   = 1;
  localparam int ONE_PULSE_BIT  = 2;
  localparam int PRELOAD_BIT    = 3;
  localparam int POLARITY_BIT   = 4;
  localparam int CH1_OE_BIT     = 5;
  localparam int MAIN_OE_BIT    = 6;
  localparam int MMS_LSB        = 8;
  localparam int SMS_LSB        = 12;
  localparam int TS_LSB         = 16;
  // update_generate register fields
  localparam int UG_MASTER_BIT  = 0;
  localparam int UG_SLAVE_BIT   = 1;
  // status / interrupt fields
  localparam int EV_MUPD   = 0;
  localparam int EV_SUPD   = 1;
  localparam int EV_TRIG   = 2;
  localparam int EV_BURST  = 3;
  localparam int EV_NUM    = 4;
  // master trigger source codes
  localparam logic [2:0] MMS_RESET   = 3'h0;
  localparam logic [2:0] MMS_ENABLE  = 3'h1;
  localparam logic [2:0] MMS_UPDATE  = 3'h2;
  localparam logic [2:0] MMS_CMPPLS  = 3'h3;
  localparam logic [2:0] MMS_OC1REF  = 3'h4;
  // slave mode / trigger source codes
  localparam logic [2:0] SMS_TRIGGER = 3'h6;
  localparam logic [1:0] TS_INTERNAL_TRIGGER_IN_1     = 2'h1;
  // reset values and the bus transfer type code
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] PSC_RESET  = 16'h0000;
  localparam logic [15:0] ARR_RESET  = 16'hFFFF;
  localparam logic [15:0] CCR_RESET  = 16'h0000;
  localparam logic [7:0]  RCR_RESET  = 8'h00;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage

// ---- periodic_n_pulse_burst_generator.sv ----
// periodic n-pulse burst generator: master timer triggers a one-pulse slave pwm timer
`timescale 1ns/1ps
// Overview of operation
// - master emits a trigger pulse on each update event to slave trigger input 1
// - burst period is set by master auto-reload value in prescaled ticks
// - trigger rising edge starts slave counter; in one-pulse mode it runs repetition count plus one full periods up to limit
// - slave update event waits until period repeats repetition count plus one times
// - slave pwm period from auto-reload, active time from channel 1 compare value
// - counter tick equals input clock divided by prescaler value plus one
// - both counters count up from zero to their auto-reload value
// - with preload on, new compare value applies only at next update event
// - after the burst the output stays at the polarity level (low when polarity is clear) until a trigger after software sets slave enable again
// - update master mode selects update event as trigger output source
module periodic_n_pulse_burst_generator #(
  parameter int CW = 16,  // counter width
  parameter int RW = 8    // repetition counter width
) (
  input  wire logic        sys_clk,    // 40 MHz clock
  input  wire logic        resetn,     // async reset, active low
  input  wire logic        hsel,       // slave select
  input  wire logic [31:0] haddr,      // byte address
  input  wire logic [1:0]  htrans,     // transfer type
  input  wire logic        hwrite,     // write strobe
  input  wire logic [2:0]  hsize,      // transfer size
  input  wire logic        hready,     // bus ready in
  input  wire logic [31:0] hwdata,     // write data
  output logic      [31:0] hrdata,     // read data
  output logic             hreadyout,  // slave ready
  output logic             hresp,      // response, always okay
  output logic             pwmOut,     // channel 1 pulse output
  output logic             triggerOut, // master trigger output
  output logic             irq         // level interrupt
);
  localparam int EV_NUM_W = npulse_pkg::EV_NUM;
  // software-visible registers
  logic [31:0]         ctrl;
  logic [CW-1:0]       mPsc;
  logic [CW-1:0]       mArr;
  logic [CW-1:0]       sPsc;
  logic [CW-1:0]       sArr;
  logic [CW-1:0]       sCcrPre;
  logic [CW-1:0]       sRcrPre;
  // live counters and the active values loaded at an update
  logic [CW-1:0]       mPscCnt;
  logic [CW-1:0]       mCnt;
  logic [CW-1:0]       sPscCnt;
  logic [CW-1:0]       sCnt;
  logic [CW-1:0]       sArrAct;
  logic [CW-1:0]       sCcrAct;
  logic [CW-1:0]       sPscAct;
  logic [CW-1:0]       mPscAct;
  logic [CW-1:0]       mArrAct;
  logic [RW-1:0]       sRcrAct;
  logic [RW-1:0]       sRep;
  logic [EV_NUM_W-1:0] status;
  logic [EV_NUM_W-1:0] intEn;
  logic                slaveRun;
  logic                trigPrev;
  logic                ugPulseM;
  logic                ugPulseS;
  // write address held over into the data phase
  logic                wrPend;
  logic [11:0]         wrAddr;

  // bus decode
  // an address phase is accepted only once the previous transfer is done
  wire busTake = hsel && hready && (htrans == npulse_pkg::HTRANS_NONSEQ);
  // the low twelve bits pick the register; higher address bits are not decoded
  wire [11:0] rdAddr = haddr[11:0];
  // writes land one cycle late, in the data phase, when hwdata is valid
  wire wrCtrl  = wrPend && wrAddr == npulse_pkg::CTRL_OFFSET;
  wire wrMPsc  = wrPend && wrAddr == npulse_pkg::M_PSC_OFFSET;
  wire wrMArr  = wrPend && wrAddr == npulse_pkg::M_ARR_OFFSET;
  wire wrSPsc  = wrPend && wrAddr == npulse_pkg::S_PSC_OFFSET;
  wire wrSArr  = wrPend && wrAddr == npulse_pkg::S_ARR_OFFSET;
  wire wrSCcr  = wrPend && wrAddr == npulse_pkg::S_CCR_OFFSET;
  wire wrSRcr  = wrPend && wrAddr == npulse_pkg::S_RCR_OFFSET;
  wire wrUg    = wrPend && wrAddr == npulse_pkg::UG_OFFSET;
  wire wrIntEn = wrPend && wrAddr == npulse_pkg::INT_EN_OFFSET;
  wire wrIntClr = wrPend && wrAddr == npulse_pkg::INT_CLR_OFFSET;

  // control fields
  wire masterEn  = ctrl[npulse_pkg::MASTER_EN_BIT];
  wire slaveEn   = ctrl[npulse_pkg::SLAVE_EN_BIT];
  wire onePulse  = ctrl[npulse_pkg::ONE_PULSE_BIT];
  wire preloadEn = ctrl[npulse_pkg::PRELOAD_BIT];
  wire polarity  = ctrl[npulse_pkg::POLARITY_BIT];
  // both enables must be set before the channel drives its waveform
  wire outEn     = ctrl[npulse_pkg::CH1_OE_BIT] && ctrl[npulse_pkg::MAIN_OE_BIT];
  wire [2:0] mmsSel = ctrl[npulse_pkg::MMS_LSB +: 3];
  wire [2:0] smsSel = ctrl[npulse_pkg::SMS_LSB +: 3];
  wire [1:0] tsSel  = ctrl[npulse_pkg::TS_LSB +: 2];

  // master time base
  // one tick every prescaler value plus one clocks
  wire mTick  = masterEn && (mPscCnt == mPscAct);
  wire mWrap  = mTick && (mCnt == mArrAct);
  wire mUpd   = mWrap || ugPulseM;
  wire [CW-1:0] next_mCnt = ugPulseM ? '0 : (mWrap ? '0 : mCnt + 1'b1);
  wire cmpRef = masterEn && (mCnt < mArrAct[CW-1:1]);
  wire cmpPulse = mTick && (mCnt == mArrAct[CW-1:1]);
  // trigger source; update mode gives one pulse per master update
  logic next_trig;
  always_comb begin
    unique case (mmsSel)
      npulse_pkg::MMS_RESET:  next_trig = ugPulseM;
      npulse_pkg::MMS_ENABLE: next_trig = masterEn;
      npulse_pkg::MMS_UPDATE: next_trig = mUpd;
      npulse_pkg::MMS_CMPPLS: next_trig = cmpPulse;
      npulse_pkg::MMS_OC1REF: next_trig = cmpRef;
      default:                next_trig = 1'b0;
    endcase
  end

  // slave trigger selection: trigger output feeds internal trigger input 1
  wire internalTriggerIn1 = triggerOut;
  wire trigSel  = (tsSel == npulse_pkg::TS_INTERNAL_TRIGGER_IN_1) ? internalTriggerIn1 : 1'b0;
  wire trigEdge = trigSel && !trigPrev;
  // a trigger while a burst runs is ignored, so a burst never restarts halfway
  wire trigStart = trigEdge && slaveEn && (smsSel == npulse_pkg::SMS_TRIGGER) && !slaveRun;
  wire sTick  = slaveRun && (sPscCnt == sPscAct);
  wire sWrap  = sTick && (sCnt == sArrAct);
  // the last repeated period raises the update and, in one-pulse mode, the stop
  wire sLast  = sWrap && (sRep == '0);
  wire sUpd   = sLast || ugPulseS;
  wire sStop  = sLast && onePulse;
  wire [RW-1:0] next_sRep = (sUpd || trigStart) ? sRcrAct :
                            (sWrap ? sRep - 1'b1 : sRep);
  // pwm mode 1: high while the count is below the compare value
  wire pwmRef = slaveRun && (sCnt < sCcrAct);
  wire next_pwm = outEn && ((pwmRef && !sStop) ^ polarity);
  wire [EV_NUM_W-1:0] events = {sStop, trigStart, sUpd, mUpd};

  // one sticky flag per event; an event in the same cycle as its clear wins
  logic [EV_NUM_W-1:0] next_status;
  genvar ev;
  generate
    for (ev = 0; ev < EV_NUM_W; ev++) begin : g_status
      assign next_status[ev] = events[ev] || (status[ev] && !(wrIntClr && hwdata[ev]));
    end
  endgenerate

  // read-back: unmapped offsets answer zero
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (rdAddr)
      npulse_pkg::CTRL_OFFSET:   rdMux = {ctrl[31:2], slaveRun, ctrl[0]};
      npulse_pkg::M_PSC_OFFSET:  rdMux[CW-1:0] = mPsc;
      npulse_pkg::M_ARR_OFFSET:  rdMux[CW-1:0] = mArr;
      npulse_pkg::S_PSC_OFFSET:  rdMux[CW-1:0] = sPsc;
      npulse_pkg::S_ARR_OFFSET:  rdMux[CW-1:0] = sArr;
      npulse_pkg::S_CCR_OFFSET:  rdMux[CW-1:0] = sCcrPre;
      npulse_pkg::S_RCR_OFFSET:  rdMux[CW-1:0] = sRcrPre;
      npulse_pkg::STATUS_OFFSET: rdMux[EV_NUM_W-1:0] = status;
      npulse_pkg::INT_EN_OFFSET: rdMux[EV_NUM_W-1:0] = intEn;
      npulse_pkg::M_CNT_OFFSET:  rdMux[CW-1:0] = mCnt;
      npulse_pkg::S_CNT_OFFSET:  rdMux[CW-1:0] = sCnt;
      default:                   rdMux = 32'h0000_0000;
    endcase
  end

  // bus slave: zero wait states, writes land in the data phase
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrPend    <= 1'b0;
      wrAddr    <= 12'h000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      // hreadyout and hresp keep their reset levels: no wait states, no errors
      wrPend <= busTake && hwrite;
      wrAddr <= rdAddr;
      if (busTake && !hwrite) begin
        hrdata <= rdMux;
      end
    end
  end

  // software registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl     <= npulse_pkg::CTRL_RESET;
      mPsc     <= CW'(npulse_pkg::PSC_RESET);
      mArr     <= CW'(npulse_pkg::ARR_RESET);
      sPsc     <= CW'(npulse_pkg::PSC_RESET);
      sArr     <= CW'(npulse_pkg::ARR_RESET);
      sCcrPre  <= CW'(npulse_pkg::CCR_RESET);
      sRcrPre  <= CW'(npulse_pkg::RCR_RESET);
      intEn    <= '0;
      status   <= '0;
      ugPulseM <= 1'b0;
      ugPulseS <= 1'b0;
    end else begin
      // a software write wins over a stop in the same cycle
      if (wrCtrl) begin
        ctrl <= hwdata;
      end else if (sStop) begin
        ctrl[npulse_pkg::SLAVE_EN_BIT] <= 1'b0;
      end
      if (wrMPsc) begin
        mPsc <= hwdata[CW-1:0];
      end
      if (wrMArr) begin
        mArr <= hwdata[CW-1:0];
      end
      if (wrSPsc) begin
        sPsc <= hwdata[CW-1:0];
      end
      if (wrSArr) begin
        sArr <= hwdata[CW-1:0];
      end
      if (wrSCcr) begin
        sCcrPre <= hwdata[CW-1:0];
      end
      if (wrSRcr) begin
        sRcrPre <= hwdata[CW-1:0];
      end
      if (wrIntEn) begin
        intEn <= hwdata[EV_NUM_W-1:0];
      end
      status   <= next_status;
      ugPulseM <= wrUg && hwdata[npulse_pkg::UG_MASTER_BIT];
      ugPulseS <= wrUg && hwdata[npulse_pkg::UG_SLAVE_BIT];
    end
  end

  // master timer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mPscCnt    <= '0;
      mCnt       <= '0;
      mPscAct    <= CW'(npulse_pkg::PSC_RESET);
      mArrAct    <= CW'(npulse_pkg::ARR_RESET);
      triggerOut <= 1'b0;
    end else begin
      if (ugPulseM || mTick || !masterEn) begin
        mPscCnt <= '0;
      end else begin
        mPscCnt <= mPscCnt + 1'b1;
      end
      if (mTick || ugPulseM) begin
        mCnt <= next_mCnt;
      end
      // a new period and prescaler take effect only at an update
      if (mUpd) begin
        mPscAct <= mPsc;
        mArrAct <= mArr;
      end
      triggerOut <= next_trig;
    end
  end

  // slave timer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      slaveRun <= 1'b0;
      trigPrev <= 1'b0;
      sPscCnt  <= '0;
      sCnt     <= '0;
      sRep     <= '0;
      sPscAct  <= CW'(npulse_pkg::PSC_RESET);
      sArrAct  <= CW'(npulse_pkg::ARR_RESET);
      sCcrAct  <= CW'(npulse_pkg::CCR_RESET);
      sRcrAct  <= RW'(npulse_pkg::RCR_RESET);
      pwmOut   <= 1'b0;
      irq      <= 1'b0;
    end else begin
      trigPrev <= trigSel;
      if (trigStart) begin
        slaveRun <= 1'b1;
      end else if (sStop || !slaveEn) begin
        slaveRun <= 1'b0;
      end
      if (!slaveRun || sTick || ugPulseS) begin
        sPscCnt <= '0;
      end else begin
        sPscCnt <= sPscCnt + 1'b1;
      end
      if (sWrap || ugPulseS || trigStart) begin
        sCnt <= '0;
      end else if (sTick) begin
        sCnt <= sCnt + 1'b1;
      end
      sRep <= next_sRep;
      // shadow values move to the active set at an update; the compare value also moves every cycle while preload is off
      if (sUpd) begin
        sPscAct <= sPsc;
        sArrAct <= sArr;
        sRcrAct <= sRcrPre[RW-1:0];
        sCcrAct <= sCcrPre;
      end else if (!preloadEn) begin
        sCcrAct <= sCcrPre;
      end
      pwmOut <= next_pwm;
      // irq follows the flags as they stand after this edge
      irq    <= |(next_status & intEn);
    end
  end
endmodule

// ---- npulse_sva.sv ----
// checker: port-level assertions of the n-pulse burst generator
`timescale 1ns/1ps
module npulse_sva #(
  parameter int M_PERIOD   = 200, // master period in clocks
  parameter int HIGH_CLKS  = 10,  // pulse high time in clocks
  parameter int PULSES     = 3,   // pulses per burst
  parameter int IDLE_AFTER = 80   // clocks after a trigger by which a burst is over
) (
  input wire logic        sys_clk,    // clock
  input wire logic        resetn,     // async reset, active low
  input wire logic        hsel,       // slave select
  input wire logic [31:0] haddr,      // byte address
  input wire logic [1:0]  htrans,     // transfer type
  input wire logic        hwrite,     // write strobe
  input wire logic        hready,     // bus ready
  input wire logic [31:0] hrdata,     // read data
  input wire logic        hreadyout,  // slave ready
  input wire logic        hresp,      // response
  input wire logic        pwmOut,     // channel output
  input wire logic        triggerOut, // master trigger
  input wire logic        irq         // interrupt
);
  logic [9:0] sinceTrig;
  logic [7:0] highLen;
  logic [7:0] pulseCnt;
  logic       pwmPrev;
  logic [1:0] trigSeen;
  wire        rdReq = hsel && hready && htrans == npulse_pkg::HTRANS_NONSEQ && !hwrite;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // cycles since last trigger, saturating; pulses and high time counted alongside
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sinceTrig <= 10'h3FF;
      highLen   <= 8'h00;
      pulseCnt  <= 8'h00;
      pwmPrev   <= 1'b0;
      trigSeen  <= 2'h0;
    end else begin
      sinceTrig <= triggerOut ? 10'h000 : (sinceTrig == 10'h3FF ? sinceTrig : sinceTrig + 10'h001);
      highLen   <= pwmOut ? highLen + 8'h01 : 8'h00;
      pulseCnt  <= triggerOut ? 8'h00 : pulseCnt + {7'h00, pwmOut && !pwmPrev};
      pwmPrev   <= pwmOut;
      trigSeen  <= (triggerOut && trigSeen != 2'h3) ? trigSeen + 2'h1 : trigSeen;
    end
  end
  a_ready_high: assert property (hreadyout) else $error("ready dropped");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_trig_single: assert property (triggerOut |=> !triggerOut) else $error("trigger not a pulse");
  // the first trigger after reset comes from the software update, not from a master wrap
  a_trig_period: assert property (triggerOut && trigSeen >= 2'h2 |-> sinceTrig == M_PERIOD - 1)
    else $error("trigger spacing wrong");
  a_pulse_count: assert property (sinceTrig == IDLE_AFTER && trigSeen >= 2'h2 |-> pulseCnt == PULSES)
    else $error("wrong pulse count");
  a_pulse_width: assert property ($fell(pwmOut) |-> highLen == HIGH_CLKS)
    else $error("wrong pulse width");
  a_idle_low: assert property (sinceTrig > IDLE_AFTER |-> !pwmOut) else $error("output high between bursts");
  a_rdata_hold: assert property (!rdReq |=> $stable(hrdata)) else $error("read data moved");
  a_unmapped_zero: assert property (rdReq && haddr == 32'h0000_0100 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  c_trig: cover property (triggerOut);
  c_pulse: cover property ($fell(pwmOut));
  c_irq: cover property ($rose(irq));
endmodule
bind periodic_n_pulse_burst_generator npulse_sva u_sva (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .pwmOut(pwmOut), .triggerOut(triggerOut), .irq(irq));

// ---- ahb_host_model.sv ----
// host model: single-word AHB-Lite master for the register bus
`timescale 1ns/1ps
module ahb_host_model (
  input  wire logic        sys_clk, // bus clock
  input  wire logic        hready,  // bus ready
  input  wire logic [31:0] hrdata,  // read data
  output logic             hsel,    // slave select
  output logic      [31:0] haddr,   // byte address
  output logic      [1:0]  htrans,  // transfer type
  output logic             hwrite,  // write strobe
  output logic      [2:0]  hsize,   // transfer size
  output logic      [31:0] hwdata   // write data
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic wr, input logic [11:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= npulse_pkg::HTRANS_NONSEQ;
    haddr  <= {20'h00000, adr};
    hwrite <= wr;
    // stale write data is not left looking valid
    hwdata <= ~hwdata;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule

// ---- test_periodic_n_pulse_burst_generator.sv ----
// testbench: register-driven burst scenarios for the n-pulse burst generator
`timescale 1ns/1ps
module test_periodic_n_pulse_burst_generator;
  logic        sys_clk;
  logic        resetn;
  wire         hsel, hwrite, hreadyout, hresp, pwmOut, triggerOut, irq;
  wire  [31:0] haddr, hwdata, hrdata;
  wire  [1:0]  htrans;
  wire  [2:0]  hsize;
  logic        pwmPrev;
  int          err_total, compares, cycles, rises;
  // master+slave enable, one pulse, preload, outputs on, update source, trigger mode, input 1
  localparam logic [31:0] CTRL_RUN = 32'h0001_626F;
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  ahb_host_model u_host (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  periodic_n_pulse_burst_generator u_dut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pwmOut(pwmOut), .triggerOut(triggerOut), .irq(irq));
  task automatic conclude();
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] unused;
    u_host.xfer(1'b1, a, d, unused);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] v;
    u_host.xfer(1'b0, a, 32'h0000_0000, v);
    check(v & mask, exp);
  endtask
  // wait for a trigger, then for the burst (3 x 10 ticks x 2 clocks) to be over
  task automatic burst();
    do @(posedge sys_clk); while (triggerOut !== 1'b1);
    repeat (80) @(posedge sys_clk);
  endtask
  initial begin
    resetn = 1'b0;
    pwmPrev = 1'b0;
    err_total = 0;
    compares = 0;
    cycles = 0;
    rises = 0;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    pwmPrev <= pwmOut;
    if (pwmOut === 1'b1 && pwmPrev === 1'b0) rises <= rises + 1;
    if (cycles == 5000) begin
      err_total = err_total + 1;
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(npulse_pkg::CTRL_OFFSET, 32'hFFFF_FFFF, npulse_pkg::CTRL_RESET);
    rd(npulse_pkg::M_ARR_OFFSET, 32'h0000_FFFF, {16'h0000, npulse_pkg::ARR_RESET});
    rd(npulse_pkg::S_PSC_OFFSET, 32'h0000_FFFF, {16'h0000, npulse_pkg::PSC_RESET});
    rd(npulse_pkg::S_CCR_OFFSET, 32'h0000_FFFF, {16'h0000, npulse_pkg::CCR_RESET});
    rd(npulse_pkg::S_RCR_OFFSET, 32'h0000_00FF, {24'h000000, npulse_pkg::RCR_RESET});
    wr(12'h100, 32'hFFFF_FFFF);
    rd(12'h100, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(npulse_pkg::S_PSC_OFFSET, 32'h0000_0001);
    wr(npulse_pkg::S_ARR_OFFSET, 32'h0000_0009);
    wr(npulse_pkg::S_CCR_OFFSET, 32'h0000_0005);
    wr(npulse_pkg::S_RCR_OFFSET, 32'h0000_0002);
    wr(npulse_pkg::M_ARR_OFFSET, 32'h0000_00C7);
    wr(npulse_pkg::UG_OFFSET, 32'h0000_0003);
    rd(npulse_pkg::M_ARR_OFFSET, 32'h0000_FFFF, 32'h0000_00C7);
    rd(npulse_pkg::S_ARR_OFFSET, 32'h0000_FFFF, 32'h0000_0009);
    wr(npulse_pkg::INT_EN_OFFSET, 32'h0000_0008);
    rd(npulse_pkg::INT_EN_OFFSET, 32'h0000_000F, 32'h0000_0008);
    wr(npulse_pkg::CTRL_OFFSET, CTRL_RUN);
    burst();
    check(32'(rises), 32'h0000_0003);
    rd(npulse_pkg::STATUS_OFFSET, 32'h0000_000F, 32'h0000_000F);
    check({31'h0, irq}, 32'h0000_0001);
    rd(npulse_pkg::CTRL_OFFSET, 32'h0000_0002, 32'h0000_0000);
    rd(npulse_pkg::S_CNT_OFFSET, 32'h0000_FFFF, 32'h0000_0000);
    // new compare must wait for the update that ends the next burst
    wr(npulse_pkg::S_CCR_OFFSET, 32'h0000_0003);
    wr(npulse_pkg::INT_CLR_OFFSET, 32'h0000_000F);
    rd(npulse_pkg::STATUS_OFFSET, 32'h0000_000F, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    wr(npulse_pkg::INT_EN_OFFSET, 32'h0000_0000);
    wr(npulse_pkg::CTRL_OFFSET, CTRL_RUN);
    burst();
    check(32'(rises), 32'h0000_0006);
    rd(npulse_pkg::STATUS_OFFSET, 32'h0000_0008, 32'h0000_0008);
    check({31'h0, irq}, 32'h0000_0000);
    wr(npulse_pkg::CTRL_OFFSET, 32'h0000_0000);
    rd(npulse_pkg::CTRL_OFFSET, 32'hFFFF_FFFF, 32'h0000_0000);
    conclude();
  end
endmodule
